// >>> common/uart_rx_pkg.sv
// Register map, field positions, reset values and counts of the serial port
`default_nettype none
package uart_rx_pkg;
	// =========================================================
	// Register indices (byte address is four times the index)
	localparam logic [11:0] MODE_IDX = 12'h020c;
	localparam logic [11:0] STATUS_IDX = 12'h020e;
	localparam logic [11:0] TXWORD_IDX = 12'h0210;
	localparam logic [11:0] RXWORD_IDX = 12'h0212;
	localparam logic [11:0] DIVISOR_IDX = 12'h0214;
	localparam int ADDR_W = 14;
	// =========================================================
	// Reset values
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] STATUS_RST = 16'h0110;
	localparam logic [15:0] DIVISOR_RST = 16'h0000;
	// =========================================================
	// Mode register fields
	localparam int MODE_ENABLE_BIT = 15;
	localparam int MODE_STOP_IDLE_BIT = 13;
	localparam int MODE_ALT_PINS_BIT = 10;
	localparam int MODE_WAKE_BIT = 7;
	localparam int MODE_LOOPBACK_BIT = 6;
	localparam int MODE_AUTOBAUD_BIT = 5;
	localparam int MODE_FORMAT_HI = 2;
	localparam int MODE_FORMAT_LO = 1;
	localparam int MODE_STOP_SEL_BIT = 0;
	// =========================================================
	// Status register fields
	localparam int STA_TX_ISEL_BIT = 15;
	localparam int STA_TX_BREAK_BIT = 11;
	localparam int STA_TX_ENABLE_BIT = 10;
	localparam int STA_TX_FULL_BIT = 9;
	localparam int STA_TX_EMPTY_BIT = 8;
	localparam int STA_RX_ISEL_HI = 7;
	localparam int STA_RX_ISEL_LO = 6;
	localparam int STA_ADDR_DET_BIT = 5;
	localparam int STA_IDLE_BIT = 4;
	localparam int STA_PARITY_ERR_BIT = 3;
	localparam int STA_FRAME_ERR_BIT = 2;
	localparam int STA_OVERRUN_BIT = 1;
	localparam int STA_DATA_AVAIL_BIT = 0;
	// =========================================================
	// Character formats
	localparam logic [1:0] FMT_8N = 2'h0;
	localparam logic [1:0] FMT_8E = 2'h1;
	localparam logic [1:0] FMT_8O = 2'h2;
	localparam logic [1:0] FMT_9N = 2'h3;
	// =========================================================
	// Sampling and buffer counts
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [2:0] RX_DEPTH = 3'h4;
	localparam logic [2:0] RX_LEVEL_THREE = 3'h3;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_WAIT_HIGH} rx_state_type;
endpackage
`default_nettype wire

// >>> hw/uart_rx_errors.sv
// Serial port receive status, errors, break, address detect, loopback, baud and low power
// Contract
// - Framing error set when any selected stop bit samples zero.
// - Framing error is read-only, buffered per word, shown for buffer head, reset-cleared.
// - Parity error set on wrong parity, only in odd or even mode.
// - Parity error is read-only, buffered per word, reset-cleared.
// - Idle flag low from start detection until stop completes, otherwise high.
// - Bit count per character follows format select and stop select.
// - Long break ends after configured bits: zero word, framing error, interrupt, idle.
// - After a bad stop, wait for high line before seeking a start bit.
// - Address detect in nine-bit mode marks ninth-bit-set words as addresses.
// - Address detect raises receive interrupt for every ninth-bit-set word stored in the buffer (none when full or overrun set).
// - Loopback feeds transmitter to receiver and ignores the receive pin.
// - Sixteen-bit divisor; baud is clock over sixteen times divisor plus one.
// - Receive line optionally routed to a capture input for auto-baud.
// - Sleep freezes the module, aborts transfers, drives transmit pin high.
// - Sleep leaves registers and buffers unchanged.
// - Wake bit set: falling receive edge in sleep raises receive interrupt.
// - Wake interrupt only while the module enable bit is set.
// - Idle mode halts the module only when stop-in-idle is set.
// - Formats: eight bits with none, even, odd parity, or nine bits.
// - Data available is high exactly while the receive buffer holds a word.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_errors
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [uart_rx_pkg::ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	input wire logic receive_pin_i,
	input wire logic alt_receive_pin_i,
	output logic transmit_pin_o,
	output logic alt_transmit_pin_o,
	output logic capture_route_o,
	input wire logic sleep_i,
	input wire logic cpu_idle_i,
	output logic rx_irq_o,
	output logic tx_irq_o
);
	// =========================================================
	// Bus slave
	logic ack_r;
	logic [31:0] readdata_r;
	wire req = read_i | write_i;
	wire wr_fire = write_i & ack_r;
	wire rd_fire = read_i & ack_r;
	wire [uart_rx_pkg::ADDR_W-1:0] idx = {2'b00, address_i[uart_rx_pkg::ADDR_W-1:2]};
	wire aligned = (address_i[1:0] == 2'b00);
	wire sel_mode = aligned & (idx[11:0] == uart_rx_pkg::MODE_IDX);
	wire sel_sta = aligned & (idx[11:0] == uart_rx_pkg::STATUS_IDX);
	wire sel_tx = aligned & (idx[11:0] == uart_rx_pkg::TXWORD_IDX);
	wire sel_rx = aligned & (idx[11:0] == uart_rx_pkg::RXWORD_IDX);
	wire sel_div = aligned & (idx[11:0] == uart_rx_pkg::DIVISOR_IDX);
	assign waitrequest_o = req & ~ack_r;
	assign readdata_o = readdata_r;

	// =========================================================
	// Registers
	logic [15:0] mode_r;
	logic [15:0] div_r;
	logic tx_isel_r, tx_brk_r, tx_en_r, address_detect_enable_r, overrun_error_flag_r;
	logic [1:0] rx_isel_r;
	function automatic logic [15:0] merge(input logic [15:0] cur, input logic [31:0] wd, input logic [3:0] be);
		merge = {be[1] ? wd[15:8] : cur[15:8], be[0] ? wd[7:0] : cur[7:0]};
	endfunction
	wire [15:0] mode_wr = merge(mode_r, writedata_i, byteenable_i);
	wire [15:0] div_wr = merge(div_r, writedata_i, byteenable_i);
	wire [15:0] sta_wr = merge({tx_isel_r, 3'b000, tx_brk_r, tx_en_r, 2'b00, rx_isel_r, address_detect_enable_r, 3'b000,
		overrun_error_flag_r, 1'b0}, writedata_i, byteenable_i);
	wire enable = mode_r[uart_rx_pkg::MODE_ENABLE_BIT];
	wire stop_idle = mode_r[uart_rx_pkg::MODE_STOP_IDLE_BIT];
	wire alt_pins = mode_r[uart_rx_pkg::MODE_ALT_PINS_BIT];
	wire wake_en = mode_r[uart_rx_pkg::MODE_WAKE_BIT];
	wire loopback = mode_r[uart_rx_pkg::MODE_LOOPBACK_BIT];
	wire autobaud = mode_r[uart_rx_pkg::MODE_AUTOBAUD_BIT];
	wire [1:0] fmt = mode_r[uart_rx_pkg::MODE_FORMAT_HI:uart_rx_pkg::MODE_FORMAT_LO];
	wire stop_bit_select = mode_r[uart_rx_pkg::MODE_STOP_SEL_BIT];
	wire nine = (fmt == uart_rx_pkg::FMT_9N);
	wire par_en = (fmt == uart_rx_pkg::FMT_8E) | (fmt == uart_rx_pkg::FMT_8O);
	wire par_odd = (fmt == uart_rx_pkg::FMT_8O);
	wire run = enable & ~sleep_i & ~(cpu_idle_i & stop_idle);
	wire abort = ~enable | sleep_i;

	// =========================================================
	// Pin synchronisers and line selection
	logic rx_m1_r, rx_s_r, arx_m1_r, arx_s_r, pin_prev_r, tx_drive_r;
	wire pin_line = alt_pins ? arx_s_r : rx_s_r;
	wire rx_line = loopback ? tx_drive_r : pin_line;
	wire wake_evt = sleep_i & enable & wake_en & pin_prev_r & ~pin_line;

	// =========================================================
	// Baud tick
	logic [15:0] baud_cnt_r;
	wire tick = run & (baud_cnt_r == 16'h0000);

	// =========================================================
	// Receiver
	uart_rx_pkg::rx_state_type rx_state_r;
	logic [3:0] rx_tcnt_r;
	logic [3:0] rx_bit_r;
	logic [8:0] rx_sh_r;
	logic rx_par_r, stop_idx_r, stop_bad_r;
	wire [3:0] nbits_m1 = nine ? 4'h8 : 4'h7;
	wire rx_mid = tick & (rx_tcnt_r == uart_rx_pkg::TICK_LAST);
	wire [8:0] rx_word = nine ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
	wire rx_parity_error_flag = par_en & ((^{rx_word[7:0], rx_par_r}) != par_odd);
	wire rx_framing_error_flag = stop_bad_r | ~rx_line;
	wire rx_done = rx_mid & (rx_state_r == uart_rx_pkg::RX_STOP) & (~stop_bit_select | stop_idx_r);
	wire addr_mode = address_detect_enable_r & nine;
	wire store_ok = rx_done & ~(addr_mode & ~rx_word[8]);

	// =========================================================
	// Receive buffer
	logic [10:0] rx_mem_r [0:3];
	logic [1:0] rd_ptr_r, wr_ptr_r;
	logic [2:0] rx_cnt_r;
	wire rx_full = (rx_cnt_r == uart_rx_pkg::RX_DEPTH);
	wire rx_avail = (rx_cnt_r != 3'h0);
	wire push_en = store_ok & ~rx_full & ~overrun_error_flag_r;
	wire pop_en = rd_fire & sel_rx & rx_avail;
	wire [10:0] head = rx_mem_r[rd_ptr_r];
	wire [2:0] cnt_after = rx_cnt_r + 3'h1;
	wire isel_hit = ~rx_isel_r[1] | (rx_isel_r[0] ? (cnt_after == uart_rx_pkg::RX_DEPTH)
		: (cnt_after == uart_rx_pkg::RX_LEVEL_THREE));
	wire push_irq = push_en & (addr_mode ? rx_word[8] : isel_hit);
	wire rx_idle = (rx_state_r == uart_rx_pkg::RX_IDLE) | (rx_state_r == uart_rx_pkg::RX_WAIT_HIGH);

	// =========================================================
	// Transmitter
	logic [8:0] hold_r;
	logic hold_full_r, tx_busy_r;
	logic [12:0] tx_frame_r;
	logic [3:0] tx_left_r, tx_tcnt_r;
	wire tx_par = par_odd ? ~(^hold_r[7:0]) : (^hold_r[7:0]);
	wire tx_bit9 = nine ? hold_r[8] : (par_en ? tx_par : 1'b1);
	wire [12:0] tx_frame = {3'b111, tx_bit9, hold_r[7:0], 1'b0};
	wire [3:0] tx_len = 4'ha + {3'b000, nine | par_en} + {3'b000, stop_bit_select};
	wire tx_load = run & ~tx_busy_r & hold_full_r & tx_en_r;
	wire tx_line = tx_busy_r ? tx_frame_r[0] : 1'b1;
	wire tx_drive = abort ? 1'b1 : (tx_brk_r ? 1'b0 : tx_line);
	wire [15:0] sta_rd = {tx_isel_r, 3'b000, tx_brk_r, tx_en_r, hold_full_r, ~tx_busy_r, rx_isel_r, address_detect_enable_r,
		rx_idle, head[10] & rx_avail, head[9] & rx_avail, overrun_error_flag_r, rx_avail};
	wire [15:0] rd_mux = sel_mode ? mode_r : sel_sta ? sta_rd : sel_rx ? {7'h00, head[8:0]}
		: sel_div ? div_r : 16'h0000;

	// =========================================================
	// Bus and register state
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			readdata_r <= 32'h0000_0000;
			mode_r <= uart_rx_pkg::MODE_RST;
			div_r <= uart_rx_pkg::DIVISOR_RST;
		end
		else
		begin
			ack_r <= req & ~ack_r;
			if (req & ~ack_r)
				readdata_r <= {16'h0000, rd_mux};
			if (wr_fire & sel_mode)
				mode_r <= mode_wr;
			if (wr_fire & sel_div)
				div_r <= div_wr;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tx_isel_r <= 1'b0;
			tx_brk_r <= 1'b0;
			tx_en_r <= 1'b0;
			rx_isel_r <= 2'b00;
			address_detect_enable_r <= 1'b0;
			overrun_error_flag_r <= 1'b0;
		end
		else
		begin
			if (wr_fire & sel_sta)
			begin
				tx_isel_r <= sta_wr[uart_rx_pkg::STA_TX_ISEL_BIT];
				tx_brk_r <= sta_wr[uart_rx_pkg::STA_TX_BREAK_BIT];
				tx_en_r <= sta_wr[uart_rx_pkg::STA_TX_ENABLE_BIT];
				rx_isel_r <= sta_wr[uart_rx_pkg::STA_RX_ISEL_HI:uart_rx_pkg::STA_RX_ISEL_LO];
				address_detect_enable_r <= sta_wr[uart_rx_pkg::STA_ADDR_DET_BIT];
				overrun_error_flag_r <= overrun_error_flag_r & sta_wr[uart_rx_pkg::STA_OVERRUN_BIT];
			end
			if (store_ok & rx_full)
				overrun_error_flag_r <= 1'b1;
			if (~enable)
			begin
				tx_brk_r <= 1'b0;
				tx_en_r <= 1'b0;
				overrun_error_flag_r <= 1'b0;
			end
		end
	end

	// =========================================================
	// Synchronisers, baud counter and pins
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_m1_r <= 1'b1;
			rx_s_r <= 1'b1;
			arx_m1_r <= 1'b1;
			arx_s_r <= 1'b1;
			pin_prev_r <= 1'b1;
			tx_drive_r <= 1'b1;
			transmit_pin_o <= 1'b1;
			alt_transmit_pin_o <= 1'b1;
			capture_route_o <= 1'b1;
			baud_cnt_r <= 16'h0000;
			rx_irq_o <= 1'b0;
		end
		else
		begin
			rx_m1_r <= receive_pin_i;
			rx_s_r <= rx_m1_r;
			arx_m1_r <= alt_receive_pin_i;
			arx_s_r <= arx_m1_r;
			pin_prev_r <= pin_line;
			tx_drive_r <= tx_drive;
			transmit_pin_o <= alt_pins ? 1'b1 : tx_drive;
			alt_transmit_pin_o <= alt_pins ? tx_drive : 1'b1;
			capture_route_o <= autobaud ? pin_line : 1'b1;
			if (~enable)
				baud_cnt_r <= div_r;
			else if (run)
				baud_cnt_r <= (baud_cnt_r == 16'h0000) ? div_r : baud_cnt_r - 16'h0001;
			rx_irq_o <= push_irq | wake_evt;
		end
	end

	// =========================================================
	// Receive state machine
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_state_r <= uart_rx_pkg::RX_IDLE;
			rx_tcnt_r <= 4'h0;
			rx_bit_r <= 4'h0;
			rx_sh_r <= 9'h000;
			rx_par_r <= 1'b0;
			stop_idx_r <= 1'b0;
			stop_bad_r <= 1'b0;
		end
		else if (abort)
			rx_state_r <= uart_rx_pkg::RX_IDLE;
		else if (run)
		begin
			if (tick)
				rx_tcnt_r <= rx_tcnt_r + 4'h1;
			case (rx_state_r)
				uart_rx_pkg::RX_IDLE:
					if (tick & ~rx_line)
					begin
						rx_state_r <= uart_rx_pkg::RX_START;
						rx_tcnt_r <= 4'h0;
					end
				uart_rx_pkg::RX_START:
					if (tick & (rx_tcnt_r == uart_rx_pkg::TICK_MID))
					begin
						rx_state_r <= rx_line ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
						rx_tcnt_r <= 4'h0;
						rx_bit_r <= 4'h0;
						stop_idx_r <= 1'b0;
						stop_bad_r <= 1'b0;
					end
				uart_rx_pkg::RX_DATA:
					if (rx_mid)
					begin
						rx_sh_r <= {rx_line, rx_sh_r[8:1]};
						rx_bit_r <= rx_bit_r + 4'h1;
						if (rx_bit_r == nbits_m1)
							rx_state_r <= par_en ? uart_rx_pkg::RX_PARITY : uart_rx_pkg::RX_STOP;
					end
				uart_rx_pkg::RX_PARITY:
					if (rx_mid)
					begin
						rx_par_r <= rx_line;
						rx_state_r <= uart_rx_pkg::RX_STOP;
					end
				uart_rx_pkg::RX_STOP:
					if (rx_mid)
					begin
						stop_bad_r <= rx_framing_error_flag;
						stop_idx_r <= 1'b1;
						if (rx_done)
							rx_state_r <= rx_line ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_WAIT_HIGH;
					end
				uart_rx_pkg::RX_WAIT_HIGH:
					if (rx_line)
						rx_state_r <= uart_rx_pkg::RX_IDLE;
				default:
					rx_state_r <= uart_rx_pkg::RX_IDLE;
			endcase
		end
	end

	// =========================================================
	// Receive buffer; sleep leaves it untouched
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rd_ptr_r <= 2'h0;
			wr_ptr_r <= 2'h0;
			rx_cnt_r <= 3'h0;
		end
		else if (~enable)
		begin
			rd_ptr_r <= 2'h0;
			wr_ptr_r <= 2'h0;
			rx_cnt_r <= 3'h0;
		end
		else
		begin
			if (push_en)
				wr_ptr_r <= wr_ptr_r + 2'h1;
			if (pop_en)
				rd_ptr_r <= rd_ptr_r + 2'h1;
			if (push_en & ~pop_en)
				rx_cnt_r <= rx_cnt_r + 3'h1;
			else if (pop_en & ~push_en)
				rx_cnt_r <= rx_cnt_r - 3'h1;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < 4; i++)
				rx_mem_r[i] <= 11'h000;
		end
		else if (push_en)
			rx_mem_r[wr_ptr_r] <= {rx_parity_error_flag, rx_framing_error_flag, rx_word};
	end

	// =========================================================
	// Transmitter
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hold_r <= 9'h000;
			hold_full_r <= 1'b0;
			tx_busy_r <= 1'b0;
			tx_frame_r <= 13'h1fff;
			tx_left_r <= 4'h0;
			tx_tcnt_r <= 4'h0;
			tx_irq_o <= 1'b0;
		end
		else
		begin
			tx_irq_o <= tx_load;
			if (~enable)
				hold_full_r <= 1'b0;
			else if (wr_fire & sel_tx & ~hold_full_r)
			begin
				hold_r <= writedata_i[8:0];
				hold_full_r <= 1'b1;
			end
			else if (tx_load)
				hold_full_r <= 1'b0;
			if (abort)
				tx_busy_r <= 1'b0;
			else if (tx_load)
			begin
				tx_busy_r <= 1'b1;
				tx_frame_r <= tx_frame;
				tx_left_r <= tx_len;
				tx_tcnt_r <= 4'h0;
			end
			else if (tx_busy_r & tick)
			begin
				tx_tcnt_r <= tx_tcnt_r + 4'h1;
				if (tx_tcnt_r == uart_rx_pkg::TICK_LAST)
				begin
					tx_frame_r <= {1'b1, tx_frame_r[12:1]};
					tx_left_r <= tx_left_r - 4'h1;
					if (tx_left_r == 4'h1)
						tx_busy_r <= 1'b0;
				end
			end
		end
	end

	// =========================================================
	// Assertions
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_bad_stop;
		(rx_state_r == uart_rx_pkg::RX_STOP) && rx_done && !rx_line && push_en |-> rx_framing_error_flag ##1 rx_mem_r[$past(wr_ptr_r)][9];
	endproperty
	a_bad_stop: assert property (p_bad_stop) else $error("bad stop not flagged");
	property p_head_flag;
		push_en && !rx_avail |=> rx_avail && (sta_rd[uart_rx_pkg::STA_FRAME_ERR_BIT] == $past(rx_framing_error_flag));
	endproperty
	a_head_flag: assert property (p_head_flag) else $error("frame flag not from head");
	property p_busy_after_start;
		run && !abort && (rx_state_r == uart_rx_pkg::RX_IDLE) && tick && !rx_line |=> !rx_idle;
	endproperty
	a_busy_after_start: assert property (p_busy_after_start) else $error("idle flag stayed high");
	property p_wait_high;
		(rx_state_r == uart_rx_pkg::RX_WAIT_HIGH) && !rx_line && !abort |=> (rx_state_r == uart_rx_pkg::RX_WAIT_HIGH) && rx_idle;
	endproperty
	a_wait_high: assert property (p_wait_high) else $error("low line taken as start");
	sequence s_tick_gap;
		!tick ##1 (tick || !run);
	endsequence
	property p_baud;
		tick && (div_r == 16'h0001) ##1 run |-> s_tick_gap;
	endproperty
	a_baud: assert property (p_baud) else $error("baud tick period wrong");
	property p_baud_gap;
		tick && (div_r == 16'h0001) && run && enable |=> !tick;
	endproperty
	a_baud_gap: assert property (p_baud_gap) else $error("baud tick too early");
	property p_sleep_pin;
		sleep_i |=> transmit_pin_o && alt_transmit_pin_o;
	endproperty
	a_sleep_pin: assert property (p_sleep_pin) else $error("transmit pin low in sleep");
	property p_wake;
		sleep_i && enable && wake_en && $fell(pin_line) |=> rx_irq_o;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake interrupt");
	property p_avail;
		push_en && !pop_en |=> rx_avail;
	endproperty
	a_avail: assert property (p_avail) else $error("data available low after store");
	property p_addr_irq;
		push_en && addr_mode && rx_word[8] |=> rx_irq_o;
	endproperty
	a_addr_irq: assert property (p_addr_irq) else $error("address word without interrupt");
endmodule
`default_nettype wire

// >>> sim/remote_serial.sv
// Remote serial transmitter that drives the receive line of the port
`timescale 1ns/1ps
`default_nettype none
module remote_serial
(
	input wire logic core_clk_i,
	output logic line_o
);
	int bit_clocks = 16;
	initial line_o = 1'b1;
	// =========================================================
	// Line level held for a number of clocks
	task automatic hold(input logic level, input int clocks);
		line_o <= level;
		repeat (clocks) @(posedge core_clk_i);
	endtask
	// =========================================================
	// One character: start, data, parity, stops, then idle
	task automatic send(input logic [8:0] data, input int nbits, input int par, input int stops,
		input logic bad_par, input logic [1:0] bad_stop);
		hold(1'b0, bit_clocks);
		for (int i = 0; i < nbits; i++)
			hold(data[i], bit_clocks);
		if (par != 0)
			hold((^data[7:0]) ^ (par == 2) ^ bad_par, bit_clocks);
		for (int i = 0; i < stops; i++)
			hold(~bad_stop[i], bit_clocks);
		hold(1'b1, bit_clocks);
	endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench of the serial port receive status logic
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk_i, rst_i, read_i, write_i, sleep_i, cpu_idle_i;
	logic [uart_rx_pkg::ADDR_W-1:0] address_i;
	logic [31:0] writedata_i;
	logic [3:0] byteenable_i;
	wire [31:0] readdata_o;
	wire waitrequest_o, receive_pin_i, transmit_pin_o, capture_route_o, rx_irq_o;
	wire alt_transmit_pin_o, tx_irq_o;
	int tx_irq_n = 0;
	logic [15:0] exp_q[$];
	logic [11:0] idx_q[$];
	int n_errors = 0;
	int compares = 0;
	int irq_n = 0;
	logic tx_low = 1'b0;
	logic [1:0] fm[8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h0, 2'h0};
	logic [7:0] two = 8'h40;
	logic [7:0] bp = 8'h30;
	logic [8:0] d;
	logic [1:0] bs;
	int n;
	uart_rx_errors uart_rx_errors_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
		.readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .receive_pin_i(receive_pin_i),
		.alt_receive_pin_i(1'b1), .transmit_pin_o(transmit_pin_o), .alt_transmit_pin_o(alt_transmit_pin_o),
		.capture_route_o(capture_route_o), .sleep_i(sleep_i), .cpu_idle_i(cpu_idle_i),
		.rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));
	remote_serial remote_serial_i (.core_clk_i(core_clk_i), .line_o(receive_pin_i));
	// =========================================================
	// Compare tasks and verdict
	task automatic check_pin(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_reg(input logic [11:0] idx, input logic [15:0] exp, input logic [31:0] got);
		check_pin($sformatf("register %h", idx), {16'h0000, exp}, got);
	endtask
	task automatic give_verdict;
		if (n_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// =========================================================
	// Avalon master
	task automatic bus(input logic [11:0] idx, input logic wr, input logic [15:0] data);
		int k;
		@(posedge core_clk_i);
		address_i <= {idx, 2'b00};
		read_i <= ~wr;
		write_i <= wr;
		writedata_i <= {16'h0000, data};
		k = 0;
		@(posedge core_clk_i);
		while (waitrequest_o !== 1'b0 && k < 50)
		begin
			k++;
			@(posedge core_clk_i);
		end
		if (k == 50)
		begin
			n_errors++;
			give_verdict();
		end
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] idx, input logic [15:0] data);
		bus(idx, 1'b1, data);
	endtask
	task automatic rd(input logic [11:0] idx, input logic [15:0] exp);
		exp_q.push_back(exp);
		idx_q.push_back(idx);
		bus(idx, 1'b0, 16'h0000);
	endtask
	// =========================================================
	// Watchers
	always @(posedge core_clk_i)
	begin
		if (read_i === 1'b1 && waitrequest_o === 1'b0)
			if (exp_q.size() > 0)
				check_reg(idx_q.pop_front(), exp_q.pop_front(), readdata_o);
			else
				check_pin("unexpected read", 32'h0000_0000, 32'h0000_0001);
		if (rx_irq_o === 1'b1)
			irq_n++;
		if (tx_irq_o === 1'b1)
			tx_irq_n++;
		if (transmit_pin_o === 1'b0)
			tx_low = 1'b1;
	end
	initial
	begin
		repeat (100000) @(posedge core_clk_i);
		n_errors++;
		give_verdict();
	end
	initial
	begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	// =========================================================
	// Main sequence
	initial
	begin
		rst_i = 1'b1;
		read_i = 1'b0;
		write_i = 1'b0;
		address_i = '0;
		writedata_i = 32'h0000_0000;
		byteenable_i = 4'hf;
		sleep_i = 1'b0;
		cpu_idle_i = 1'b0;
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		void'($urandom(16));
		rd(uart_rx_pkg::MODE_IDX, uart_rx_pkg::MODE_RST);
		rd(uart_rx_pkg::STATUS_IDX, uart_rx_pkg::STATUS_RST);
		rd(uart_rx_pkg::DIVISOR_IDX, uart_rx_pkg::DIVISOR_RST);
		rd(uart_rx_pkg::RXWORD_IDX, 16'h0000);
		rd(12'h0fff, 16'h0000);
		d = 9'($urandom);
		wr(uart_rx_pkg::DIVISOR_IDX, 16'hffff);
		rd(uart_rx_pkg::DIVISOR_IDX, 16'hffff);
		wr(uart_rx_pkg::DIVISOR_IDX, 16'h0001);
		wr(uart_rx_pkg::MODE_IDX, 16'h8000);
		remote_serial_i.bit_clocks = 32;
		remote_serial_i.send(d, 8, 0, 1, 1'b0, 2'b00);
		rd(uart_rx_pkg::RXWORD_IDX, {8'h00, d[7:0]});
		remote_serial_i.bit_clocks = 16;
		wr(uart_rx_pkg::DIVISOR_IDX, 16'h0000);
		n = irq_n;
		for (int i = 0; i < 8; i++)
		begin
			bs = (i == 6) ? 2'b10 : ((i == 7) ? 2'b01 : 2'b00);
			d = 9'($urandom);
			if (fm[i] != 2'h3)
				d[8] = 1'b0;
			wr(uart_rx_pkg::MODE_IDX, 16'h8000 | (16'(fm[i]) << 1) | 16'(two[i]));
			fork
				remote_serial_i.send(d, (fm[i] == 2'h3) ? 9 : 8, (fm[i] == 2'h3) ? 0 : int'(fm[i]),
					two[i] ? 2 : 1, bp[i], bs);
				begin
					repeat (40) @(posedge core_clk_i);
					rd(uart_rx_pkg::STATUS_IDX, 16'h0100);
				end
			join
			rd(uart_rx_pkg::STATUS_IDX, 16'h0111 | (16'(bp[i]) << 3) | (16'(bs != 0) << 2));
			rd(uart_rx_pkg::RXWORD_IDX, 16'(d));
			rd(uart_rx_pkg::STATUS_IDX, 16'h0110);
		end
		check_pin("rx irq count", 32'(n + 8), 32'(irq_n));
		wr(uart_rx_pkg::MODE_IDX, 16'h8000);
		remote_serial_i.hold(1'b0, 16 * 20);
		remote_serial_i.hold(1'b1, 32);
		rd(uart_rx_pkg::STATUS_IDX, 16'h0115);
		rd(uart_rx_pkg::RXWORD_IDX, 16'h0000);
		rd(uart_rx_pkg::STATUS_IDX, 16'h0110);
		wr(uart_rx_pkg::MODE_IDX, 16'h8006);
		wr(uart_rx_pkg::STATUS_IDX, 16'h00e0);
		n = irq_n;
		remote_serial_i.send(9'h055, 9, 0, 1, 1'b0, 2'b00);
		remote_serial_i.send(9'h1a5, 9, 0, 1, 1'b0, 2'b00);
		check_pin("address irq count", 32'(n + 1), 32'(irq_n));
		rd(uart_rx_pkg::STATUS_IDX, 16'h01f1);
		rd(uart_rx_pkg::RXWORD_IDX, 16'h01a5);
		wr(uart_rx_pkg::STATUS_IDX, 16'h0000);
		wr(uart_rx_pkg::MODE_IDX, 16'h8040);
		wr(uart_rx_pkg::STATUS_IDX, 16'h0400);
		remote_serial_i.hold(1'b0, 1);
		wr(uart_rx_pkg::TXWORD_IDX, 16'h005a);
		repeat (200) @(posedge core_clk_i);
		rd(uart_rx_pkg::RXWORD_IDX, 16'h005a);
		check_pin("transmit pin active", 32'h0000_0001, 32'(tx_low));
		check_pin("tx irq count", 32'h0000_0001, 32'(tx_irq_n));
		remote_serial_i.hold(1'b1, 32);
		wr(uart_rx_pkg::MODE_IDX, 16'h8080);
		wr(uart_rx_pkg::TXWORD_IDX, 16'h0000);
		repeat (40) @(posedge core_clk_i);
		sleep_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		check_pin("transmit pin in sleep", 32'h0000_0001, 32'(transmit_pin_o));
		check_pin("alt transmit pin in sleep", 32'h0000_0001, 32'(alt_transmit_pin_o));
		n = irq_n;
		remote_serial_i.hold(1'b0, 8);
		remote_serial_i.hold(1'b1, 8);
		check_pin("wake irq count", 32'(n + 1), 32'(irq_n));
		sleep_i <= 1'b0;
		rd(uart_rx_pkg::MODE_IDX, 16'h8080);
		wr(uart_rx_pkg::MODE_IDX, 16'h0080);
		sleep_i <= 1'b1;
		remote_serial_i.hold(1'b0, 8);
		remote_serial_i.hold(1'b1, 8);
		check_pin("disabled wake irq count", 32'(n + 1), 32'(irq_n));
		sleep_i <= 1'b0;
		wr(uart_rx_pkg::MODE_IDX, 16'h8000);
		wr(uart_rx_pkg::STATUS_IDX, 16'h0000);
		cpu_idle_i <= 1'b1;
		remote_serial_i.send(9'h03c, 8, 0, 1, 1'b0, 2'b00);
		cpu_idle_i <= 1'b0;
		rd(uart_rx_pkg::RXWORD_IDX, 16'h003c);
		wr(uart_rx_pkg::MODE_IDX, 16'ha000);
		cpu_idle_i <= 1'b1;
		remote_serial_i.send(9'h0c3, 8, 0, 1, 1'b0, 2'b00);
		cpu_idle_i <= 1'b0;
		rd(uart_rx_pkg::STATUS_IDX, 16'h0110);
		wr(uart_rx_pkg::MODE_IDX, 16'h8020);
		remote_serial_i.hold(1'b0, 6);
		check_pin("capture low", 32'h0000_0000, 32'(capture_route_o));
		remote_serial_i.hold(1'b1, 6);
		check_pin("capture high", 32'h0000_0001, 32'(capture_route_o));
		give_verdict();
	end
endmodule
`default_nettype wire
